// file: hw/bsp_pkg.sv
// Shared constants and types for the burst-of-four SRAM port.
// Assumes one core clock; all port pins are asynchronous to it.
package bsp_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int BSP_DATA_W   = 18;         // Beat width
	localparam int BSP_ADDR_W   = 6;          // Location bus width
	localparam int BSP_BEATS    = 4;          // Beats per burst
	localparam int BSP_BEAT_W   = 2;          // Beat index width
	localparam int BSP_READ_LAT = 3;          // Master cycles to first read beat
	localparam int BSP_PIPE_LEN = BSP_READ_LAT + 2;
	localparam int BSP_BUF_DEPTH = 2;         // Write buffer entries

	// ------------------------------------------------------------
	// Strap encodings
	// ------------------------------------------------------------
	localparam logic [1:0] BSP_STRENGTH_OFF = 2'h0;  // No termination
	localparam logic [1:0] BSP_STRENGTH_NOM = 2'h1;  // Nominal resistance
	localparam logic [1:0] BSP_STRENGTH_DBL = 2'h2;  // Double resistance
	localparam int         BSP_GRP_CLK_BIT  = 0;     // Gates clock inputs
	localparam int         BSP_GRP_ADDR_BIT = 1;     // Gates address/control

	// Select pins as sampled: {fetch_n, store_n}
	localparam logic [1:0] BSP_SEL_WRITE = 2'h2;
	localparam logic [1:0] BSP_SEL_NOP   = 2'h3;

	// ------------------------------------------------------------
	// Calibration timing, in master clock cycles
	// ------------------------------------------------------------
	localparam int BSP_CNT_W        = 24;
	localparam int BSP_CAL_CYCLES   = 163840;
	localparam int BSP_RECAL_CYCLES = 163840;

	// Command decoded at a master clock rising edge
	typedef enum logic [1:0] {
		BSP_NOP,
		BSP_WRITE,
		BSP_READ
	} bsp_cmd_e;

endpackage

// file: hw/bsp_sram_port.sv
// Burst-of-four SRAM port: command decode, DDR beats, termination control.
// Assumes master and write data clocks are pins far slower than ref_clk.
//
// Contract
// - Both selects high is nop; store low is write; fetch low is read (the code decodes both selects low as read).
// - Read beats leave on echo clock edges from n+3 to n+4.5.
// - Strength off: idle output bus floats three cycles after nop/write.
// - Strength on: idle output bus driven low three cycles after nop/write.
// - Strength code picks nominal or double; group bits gate clock, address terms.
// - Strength code 00 turns all termination off.
// - Boundary-scan high-impedance instructions turn all termination off.
// - Termination calibrated within 160K cycles after reset release.
// - Termination recalibrates periodically without controller action.
// - Commands ignored while reset is high.
`timescale 1ns/1ps
module bsp_sram_port
	import bsp_pkg::*;
#(
	parameter int DW         = BSP_DATA_W,
	parameter int AW         = BSP_ADDR_W,
	parameter int CAL_CYCLES = BSP_CAL_CYCLES,
	parameter int RECAL_CYCLES = BSP_RECAL_CYCLES
) (
	// Core clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset,
	// Command pins
	input  wire logic          masterClk,
	input  wire logic          fetchSel_n,
	input  wire logic          storeSel_n,
	input  wire logic [AW-1:0] locationBus,
	// Write data pins
	input  wire logic          writeDataClk,
	input  wire logic [DW-1:0] writeData,
	// Read data pins
	output logic               echoClk,
	output logic               echoClk_n,
	output logic      [DW-1:0] readData,
	output logic               readDataOe_n,
	// Straps and scan
	input  wire logic [1:0]    termStrengthStrap,
	input  wire logic [1:0]    termGroupStrap,
	input  wire logic          scanHighZ,
	// Termination control
	output logic               termClkOn,
	output logic               termAddrOn,
	output logic               termDataOn,
	output logic               termDouble,
	output logic               calDone,
	output logic               calUpdate
);
	localparam int WW = BSP_BEATS * DW;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0]      ckS1_r, ckS2_r;       // {kd, ck}
	logic [1:0]      edgePrev_r;
	logic [1:0]      selS1_r, selS2_r;     // {fetch_n, store_n}
	logic [AW-1:0]   locS1_r, locS2_r;
	logic [DW-1:0]   datS1_r, datS2_r;
	logic [4:0]      strapS1_r, strapS2_r; // {scan, group, strength}

	// Two flops each; only the second stage feeds logic
	always_ff @(posedge ref_clk) begin
		ckS1_r    <= {writeDataClk, masterClk};
		ckS2_r    <= ckS1_r;
		selS1_r   <= {fetchSel_n, storeSel_n};
		selS2_r   <= selS1_r;
		locS1_r   <= locationBus;
		locS2_r   <= locS1_r;
		datS1_r   <= writeData;
		datS2_r   <= datS1_r;
		strapS1_r <= {scanHighZ, termGroupStrap, termStrengthStrap};
		strapS2_r <= strapS1_r;
	end

	// Edge history of the settled clock levels
	// Tracks the pins in reset too, so a high clock at release is no false edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			edgePrev_r <= ckS2_r;
		end else begin
			edgePrev_r <= ckS2_r;
		end
	end

	// ------------------------------------------------------------
	// Edges and command decode
	// ------------------------------------------------------------
	wire             ckRise  = ckS2_r[0] & ~edgePrev_r[0];
	wire             ckFall  = ~ckS2_r[0] & edgePrev_r[0];
	wire             kdEdge  = ckS2_r[1] ^ edgePrev_r[1];
	wire [1:0]       strength = strapS2_r[1:0];
	wire [1:0]       group    = strapS2_r[3:2];
	wire             scanZ    = strapS2_r[4];
	wire             isRead   = ~selS2_r[1];
	wire             isWrite  = (selS2_r == BSP_SEL_WRITE);
	wire bsp_cmd_e   cmdNow   = isRead ? BSP_READ : (isWrite ? BSP_WRITE : BSP_NOP);

	// ------------------------------------------------------------
	// Write beat assembly
	// ------------------------------------------------------------
	logic                wrArm_r;
	logic [AW-1:0]       wrArmAddr_r;
	logic                wrOn_r;
	logic [AW-1:0]       wrAddr_r;
	logic [BSP_BEAT_W-1:0] wrBeat_r;
	logic [WW-1:0]       wrWord_r;
	logic                wrFull_r;
	wire                 bufInReady;
	wire                 bufOutValid;
	wire                 bufOutReady;
	wire [AW+WW-1:0]     bufOutData;

	// Beats start at the data clock edge that matches master edge n+1
	wire                 wrStart  = ckRise & wrArm_r;
	wire                 wrTake   = kdEdge & (wrOn_r | wrStart);
	wire [BSP_BEAT_W-1:0] wrIdx   = wrStart ? '0 : wrBeat_r;
	wire                 wrLast   = (wrIdx == BSP_BEAT_W'(BSP_BEATS-1));

	// Arm on a sampled write; reset holds all commands off
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wrArm_r     <= 1'b0;
			wrArmAddr_r <= '0;
		end else if (ckRise) begin
			wrArm_r     <= isWrite;
			wrArmAddr_r <= locS2_r;
		end
	end

	// Collect both edges of the write data clock into one word
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wrOn_r   <= 1'b0;
			wrAddr_r <= '0;
			wrBeat_r <= '0;
			wrWord_r <= '0;
			wrFull_r <= 1'b0;
		end else begin
			if (wrStart) begin
				wrAddr_r <= wrArmAddr_r;
			end
			if (wrTake) begin
				wrWord_r[wrIdx*DW +: DW] <= datS2_r;
				wrBeat_r <= wrIdx + 1'b1;
				wrOn_r   <= ~wrLast;
			end else if (wrStart) begin
				wrOn_r   <= 1'b1;
				wrBeat_r <= '0;
			end
			if (wrTake & wrLast) begin
				wrFull_r <= 1'b1;
			end else if (bufInReady) begin
				wrFull_r <= 1'b0;
			end
		end
	end

	// Buffer rides out cycles where a read fetch owns the array
	bsp_wr_buffer #(
		.WIDTH (AW + WW),
		.DEPTH (BSP_BUF_DEPTH)
	) u_wr_buffer (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.inValid  (wrFull_r),
		.inReady  (bufInReady),
		.inData   ({wrAddr_r, wrWord_r}),
		.outValid (bufOutValid),
		.outReady (bufOutReady),
		.outData  (bufOutData)
	);

	// ------------------------------------------------------------
	// Array, single port: read fetch wins over write drain
	// ------------------------------------------------------------
	logic [WW-1:0] mem [0:(1<<AW)-1];
	wire           rdFetch = ckRise & isRead;
	assign bufOutReady = ~rdFetch;

	always_ff @(posedge ref_clk) begin
		if (bufOutValid & bufOutReady) begin
			mem[bufOutData[AW+WW-1 -: AW]] <= bufOutData[WW-1:0];
		end
	end

	// ------------------------------------------------------------
	// Read pipeline, one stage per master cycle
	// ------------------------------------------------------------
	bsp_cmd_e      cmdPipe_r  [0:BSP_PIPE_LEN-1];
	logic [WW-1:0] wordPipe_r [0:BSP_PIPE_LEN-1];

	// Fetch happens at the command edge, so later writes do not leak in
	generate
		for (genvar i = 0; i < BSP_PIPE_LEN; i++) begin : g_pipe
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					cmdPipe_r[i]  <= BSP_NOP;
					wordPipe_r[i] <= '0;
				end else if (ckRise) begin
					if (i == 0) begin
						cmdPipe_r[i]  <= cmdNow;
						wordPipe_r[i] <= mem[locS2_r];
					end else begin
						cmdPipe_r[i]  <= cmdPipe_r[(i > 0) ? i-1 : 0];
						wordPipe_r[i] <= wordPipe_r[(i > 0) ? i-1 : 0];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Output beats and echo clock
	// ------------------------------------------------------------
	localparam int S_FIRST = BSP_READ_LAT - 1;   // Pre-shift stage of cmd n
	wire riseHead = (cmdPipe_r[S_FIRST] == BSP_READ);
	wire riseTail = (cmdPipe_r[S_FIRST+1] == BSP_READ);
	wire fallHead = (cmdPipe_r[S_FIRST+1] == BSP_READ);
	wire fallTail = (cmdPipe_r[S_FIRST+2] == BSP_READ);
	wire idleFloat = (strength == BSP_STRENGTH_OFF);

	// Idle slots float or pull low by strength, never stale data
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			readData     <= '0;
			readDataOe_n <= 1'b1;
			echoClk      <= 1'b0;
			echoClk_n    <= 1'b1;
		end else if (ckRise) begin
			echoClk   <= 1'b1;
			echoClk_n <= 1'b0;
			if (riseHead) begin
				readData     <= wordPipe_r[S_FIRST][0 +: DW];
				readDataOe_n <= 1'b0;
			end else if (riseTail) begin
				readData     <= wordPipe_r[S_FIRST+1][2*DW +: DW];
				readDataOe_n <= 1'b0;
			end else begin
				readData     <= '0;
				readDataOe_n <= idleFloat;
			end
		end else if (ckFall) begin
			echoClk   <= 1'b0;
			echoClk_n <= 1'b1;
			if (fallHead) begin
				readData     <= wordPipe_r[S_FIRST+1][DW +: DW];
				readDataOe_n <= 1'b0;
			end else if (fallTail) begin
				readData     <= wordPipe_r[S_FIRST+2][3*DW +: DW];
				readDataOe_n <= 1'b0;
			end else begin
				readData     <= '0;
				readDataOe_n <= idleFloat;
			end
		end
	end

	// ------------------------------------------------------------
	// Termination select; code 11 is the board's to avoid
	// ------------------------------------------------------------
	wire termAny = ((strength == BSP_STRENGTH_NOM) | (strength == BSP_STRENGTH_DBL))
		& ~scanZ;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			termClkOn  <= 1'b0;
			termAddrOn <= 1'b0;
			termDataOn <= 1'b0;
			termDouble <= 1'b0;
		end else begin
			termClkOn  <= termAny & group[BSP_GRP_CLK_BIT];
			termAddrOn <= termAny & group[BSP_GRP_ADDR_BIT];
			termDataOn <= termAny;
			termDouble <= termAny & (strength == BSP_STRENGTH_DBL);
		end
	end

	// ------------------------------------------------------------
	// Calibration: initial window, then periodic update pulses
	// ------------------------------------------------------------
	logic [BSP_CNT_W-1:0] calCnt_r;
	wire                  calEnd   = (calCnt_r == BSP_CNT_W'(CAL_CYCLES - 1));
	wire                  recalEnd = (calCnt_r == BSP_CNT_W'(RECAL_CYCLES - 1));

	// Counts master cycles only, so a stopped clock stalls it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			calCnt_r  <= '0;
			calDone   <= 1'b0;
			calUpdate <= 1'b0;
		end else begin
			calUpdate <= 1'b0;
			if (ckRise) begin
				if (!calDone && calEnd) begin
					calDone  <= 1'b1;
					calCnt_r <= '0;
				end else if (calDone && recalEnd) begin
					calUpdate <= 1'b1;
					calCnt_r  <= '0;
				end else begin
					calCnt_r <= calCnt_r + 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence rdSlot;
		ckRise && riseHead;
	endsequence
	sequence idleSlot;
		ckRise && !riseHead && !riseTail;
	endsequence

	a_write_decode: assert property (ckRise && selS2_r == BSP_SEL_WRITE |=> wrArm_r && wrArmAddr_r == $past(locS2_r))
		else $error("write not armed");
	a_nop_decode: assert property (ckRise && selS2_r == BSP_SEL_NOP |=> !wrArm_r && cmdPipe_r[0] == BSP_NOP)
		else $error("nop decoded as access");
	a_read_first: assert property (rdSlot |=> !readDataOe_n && readData == $past(wordPipe_r[S_FIRST][DW-1:0]))
		else $error("first read beat wrong");
	a_idle_float: assert property (idleSlot ##0 idleFloat |=> readDataOe_n)
		else $error("idle bus not floated");
	a_idle_low: assert property (idleSlot ##0 !idleFloat |=> !readDataOe_n && readData == '0)
		else $error("idle bus not low");
	a_term_nominal: assert property (strength == BSP_STRENGTH_NOM && !scanZ |=> termDataOn && !termDouble && termClkOn == $past(group[0]))
		else $error("nominal termination wrong");
	a_strength_off: assert property (strength == BSP_STRENGTH_OFF |=> !termClkOn && !termAddrOn && !termDataOn)
		else $error("termination on with code 00");
	a_scan_off: assert property (scanZ |=> !termClkOn && !termAddrOn && !termDataOn)
		else $error("termination on during scan");
	a_cal_window: assert property ($rose(calDone) |-> $past(calCnt_r) == BSP_CNT_W'(CAL_CYCLES - 1))
		else $error("calibration done at wrong count");
	a_recal_pulse: assert property (calUpdate |-> calDone ##1 !calUpdate)
		else $error("recalibration pulse misplaced");
	a_reset_quiet: assert property (@(posedge ref_clk) disable iff (1'b0) reset |=> !wrArm_r && cmdPipe_r[0] == BSP_NOP)
		else $error("command taken during reset");
	a_back_to_back: assert property (ckRise && cmdPipe_r[0] == BSP_READ && isWrite |=> wrArm_r && cmdPipe_r[1] == BSP_READ)
		else $error("back to back command lost");
endmodule

// file: hw/bsp_wr_buffer.sv
// Two-entry word buffer between write beat assembly and the array.
// Assumes both sides on the same clock; drain may stall at will.
`timescale 1ns/1ps
module bsp_wr_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] slot_r [0:DEPTH-1];
	logic [PW-1:0]    wrPtr_r;
	logic [PW-1:0]    rdPtr_r;
	logic [PW:0]      count_r;
	wire              push;
	wire              pop;

	// Honest full and empty from the occupancy count
	assign inReady  = (count_r != (PW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = slot_r[rdPtr_r];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Storage, no reset needed on data
	always_ff @(posedge ref_clk) begin
		if (push) begin
			slot_r[wrPtr_r] <= inData;
		end
	end

	// Pointers wrap at DEPTH
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
			end
			count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// file: verification/bsp_ctrl_model.sv
// Behavioural memory controller that drives the port pins of the SRAM port.
// Assumes ref_clk is the bench clock; requests are held until reqTaken.
`timescale 1ns/1ps
module bsp_ctrl_model
	import bsp_pkg::*;
(
	// Bench clock
	ref_clk,
	// Request side
	reqValid,
	reqRead,
	reqAddr,
	reqWord,
	reqTaken,
	// Port pins
	masterClk,
	writeDataClk,
	fetchSel_n,
	storeSel_n,
	locationBus,
	writeData
);
	input  wire logic                             ref_clk;
	input  wire logic                             reqValid;
	input  wire logic                             reqRead;
	input  wire logic [BSP_ADDR_W-1:0]            reqAddr;
	input  wire logic [BSP_BEATS*BSP_DATA_W-1:0]  reqWord;
	output logic                                  reqTaken;
	output logic                                  masterClk;
	output logic                                  writeDataClk;
	output logic                                  fetchSel_n;
	output logic                                  storeSel_n;
	output logic      [BSP_ADDR_W-1:0]            locationBus;
	output logic      [BSP_DATA_W-1:0]            writeData;

	int                                 phaseAcc;  // Picoseconds into half period
	logic                               midDone;
	logic                               loaded;
	logic [2:0]                         wrStep;
	logic [BSP_BEATS*BSP_DATA_W-1:0]    wrWord;

	// Pins start driven, never floating, since inputs are terminated
	initial begin
		phaseAcc = 17000;
		midDone = 1'b0;
		loaded = 1'b0;
		wrStep = 3'h0;
		wrWord = '0;
		reqTaken = 1'b0;
		masterClk = 1'b0;
		writeDataClk = 1'b0;
		fetchSel_n = 1'b1;
		storeSel_n = 1'b1;
		locationBus = '0;
		writeData = '0;
	end

	// ------------------------------------------------------------
	// Free-running 125 ns clocks; pins change mid half period only
	// ------------------------------------------------------------
	// Changing data mid-phase keeps it clear of the sampling edges
	always @(posedge ref_clk) begin
		reqTaken <= 1'b0;
		if (phaseAcc + 4000 >= 62500) begin
			phaseAcc <= phaseAcc + 4000 - 62500;
			midDone <= 1'b0;
			masterClk <= ~masterClk;
			writeDataClk <= ~masterClk;
			if (!masterClk && loaded) begin
				reqTaken <= 1'b1;
				loaded <= 1'b0;
				if (!reqRead) begin
					wrStep <= 3'h6;
					wrWord <= reqWord;
				end
			end
		end else begin
			phaseAcc <= phaseAcc + 4000;
			if (!midDone && phaseAcc + 4000 >= 31250) begin
				midDone <= 1'b1;
				if (!masterClk && reqValid && !loaded) begin
					fetchSel_n <= !reqRead;
					storeSel_n <= reqRead;
					locationBus <= reqAddr;
					loaded <= 1'b1;
				end else if (masterClk) begin
					fetchSel_n <= 1'b1;
					storeSel_n <= 1'b1;
					locationBus <= ~locationBus;
				end
				// Beats sit across edges n+1 to n+2.5, then the bus is scrambled
				if (wrStep >= 3'h2 && wrStep <= 3'h5) begin
					writeData <= wrWord[(5-int'(wrStep))*BSP_DATA_W +: BSP_DATA_W];
				end else if (wrStep == 3'h1) begin
					writeData <= ~writeData;
				end
				if (wrStep != 3'h0) begin
					wrStep <= wrStep - 3'h1;
				end
			end
		end
	end
endmodule

// file: verification/bsp_sram_port_tb.sv
// Self-checking bench for the SRAM port with a controller model in front.
// Assumes short calibration counts passed as parameters.
`timescale 1ns/1ps
module bsp_sram_port_tb;
	import bsp_pkg::*;

	localparam int WW = BSP_BEATS*BSP_DATA_W;

	logic                  ref_clk = 1'b0;
	logic                  reset;
	logic                  reqValid, reqRead, reqTaken;
	logic [BSP_ADDR_W-1:0] reqAddr;
	logic [WW-1:0]         reqWord;
	logic                  masterClk, writeDataClk, fetchSel_n, storeSel_n;
	logic [BSP_ADDR_W-1:0] locationBus;
	logic [BSP_DATA_W-1:0] writeData, readData;
	logic                  echoClk, echoClk_n, readDataOe_n, scanHighZ;
	logic [1:0]            termStrengthStrap, termGroupStrap;
	logic                  termClkOn, termAddrOn, termDataOn, termDouble, calDone, calUpdate;
	logic [WW-1:0]         shadow [2**BSP_ADDR_W];
	int                    failCount = 0;
	int                    samplesChecked = 0;

	always #2 ref_clk = ~ref_clk;

	bsp_ctrl_model u_ctrl (.ref_clk(ref_clk), .reqValid(reqValid), .reqRead(reqRead),
		.reqAddr(reqAddr), .reqWord(reqWord), .reqTaken(reqTaken), .masterClk(masterClk),
		.writeDataClk(writeDataClk), .fetchSel_n(fetchSel_n), .storeSel_n(storeSel_n),
		.locationBus(locationBus), .writeData(writeData));

	bsp_sram_port #(.CAL_CYCLES(8), .RECAL_CYCLES(16)) u_dut (.ref_clk(ref_clk),
		.reset(reset), .masterClk(masterClk), .fetchSel_n(fetchSel_n),
		.storeSel_n(storeSel_n), .locationBus(locationBus), .writeDataClk(writeDataClk),
		.writeData(writeData), .echoClk(echoClk), .echoClk_n(echoClk_n), .readData(readData),
		.readDataOe_n(readDataOe_n), .termStrengthStrap(termStrengthStrap),
		.termGroupStrap(termGroupStrap), .scanHighZ(scanHighZ), .termClkOn(termClkOn),
		.termAddrOn(termAddrOn), .termDataOn(termDataOn), .termDouble(termDouble),
		.calDone(calDone), .calUpdate(calUpdate));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic printVerdict();
		if (failCount == 0 && samplesChecked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [WW-1:0] got, input logic [WW-1:0] exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			failCount++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [WW-1:0] wordOf(input int i);
		logic [WW-1:0] w;
		for (int b = 0; b < BSP_BEATS; b++) w[b*BSP_DATA_W +: BSP_DATA_W] = 18'h2A5A5 ^ BSP_DATA_W'(i*16+b);
		return w;
	endfunction

	// Holds the request until the model reports the command edge
	task automatic issue(input logic rd, input logic [BSP_ADDR_W-1:0] a, input logic [WW-1:0] w);
		reqRead <= rd;
		reqAddr <= a;
		reqWord <= w;
		reqValid <= 1'b1;
		@(posedge ref_clk);
		while (reqTaken !== 1'b1) @(posedge ref_clk);
		reqValid <= 1'b0;
		@(posedge ref_clk); // Next call never re-raises valid in the same step
	endtask

	// Beats alternate echo phases; the slot after the burst is idle
	task automatic checkBeats(input int rises, input logic [WW-1:0] exp);
		logic [20:0] got, want;
		repeat (rises) @(posedge masterClk);
		for (int k = 0; k < BSP_BEATS; k++) begin
			if (k % 2 == 0) @(negedge masterClk);
			else @(posedge masterClk);
			got = {echoClk, echoClk_n, readDataOe_n, readData};
			want = {k % 2 == 0, k % 2 != 0, 1'b0, exp[k*BSP_DATA_W +: BSP_DATA_W]};
			cmp(WW'(got), WW'(want), "read beat");
		end
		@(negedge masterClk);
		want = {2'h0, termStrengthStrap == BSP_STRENGTH_OFF, BSP_DATA_W'(0)};
		cmp(WW'({readDataOe_n, readData}), WW'(want[18:0]), "idle bus");
	endtask

	task automatic doWrite(input logic [BSP_ADDR_W-1:0] a, input logic [WW-1:0] w);
		issue(1'b0, a, w);
		shadow[a] = w;
		repeat (4) @(posedge masterClk);
	endtask

	task automatic doRead(input logic [BSP_ADDR_W-1:0] a);
		issue(1'b1, a, '0);
		checkBeats(3, shadow[a]);
	endtask

	task automatic waitCal();
		repeat (11) @(posedge masterClk);
		cmp(WW'(calDone), WW'(1'b1), "calibration done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic got;
		logic on;
		reset = 1'b1;
		reqValid = 1'b0;
		reqRead = 1'b0;
		reqAddr = '0;
		reqWord = '0;
		termStrengthStrap = BSP_STRENGTH_NOM;
		termGroupStrap = 2'h3;
		scanHighZ = 1'b0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		cmp(WW'(calDone), WW'(1'b0), "calibration early");
		waitCal();
		got = 1'b0;
		repeat (20*32) begin
			@(posedge ref_clk);
			if (calUpdate === 1'b1) got = 1'b1;
		end
		cmp(WW'(got), WW'(1'b1), "recalibration pulse");
		// Strap sweep, reserved strength code 11 never applied
		for (int s = 0; s < 3; s++) for (int g = 0; g < 4; g++) for (int z = 0; z < 2; z++) begin
			termStrengthStrap <= 2'(s);
			termGroupStrap <= 2'(g);
			scanHighZ <= z[0];
			repeat (6) @(posedge ref_clk);
			on = (s != 0) && (z == 0);
			cmp(WW'({termClkOn, termAddrOn, termDataOn, termDouble}),
				WW'({on & g[0], on & g[1], on, on & (s == 2)}), "termination");
		end
		scanHighZ <= 1'b0;
		// Write then read under strength codes 00, 01 and 10
		for (int c = 0; c < 3; c++) begin
			termStrengthStrap <= 2'(c);
			doWrite(BSP_ADDR_W'(c+1), wordOf(c));
			doRead(BSP_ADDR_W'(c+1));
		end
		// Write then read back to back: read sees the array before the write
		doWrite(6'h08, wordOf(3));
		issue(1'b0, 6'h08, wordOf(4));
		issue(1'b1, 6'h08, '0);
		checkBeats(3, shadow[8]);
		shadow[8] = wordOf(4);
		repeat (4) @(posedge masterClk);
		doRead(6'h08);
		// Read then write back to back
		doWrite(6'h09, wordOf(5));
		issue(1'b1, 6'h09, '0);
		issue(1'b0, 6'h09, wordOf(6));
		checkBeats(2, shadow[9]);
		shadow[9] = wordOf(6);
		repeat (4) @(posedge masterClk);
		doRead(6'h09);
		// Read sampled in reset, reset dropped while the clock is high: no burst
		@(posedge ref_clk);
		reset <= 1'b1;
		issue(1'b1, 6'h09, '0);
		repeat (2) @(posedge ref_clk);
		cmp(WW'({echoClk, readDataOe_n}), WW'(2'h1), "read in reset");
		reset <= 1'b0;
		repeat (3) @(posedge masterClk);
		@(negedge masterClk);
		cmp(WW'({echoClk, echoClk_n, readDataOe_n, readData}),
			WW'({2'h2, termStrengthStrap == BSP_STRENGTH_OFF, BSP_DATA_W'(0)}),
			"burst after reset");
		waitCal();
		doRead(6'h09);
		printVerdict();
	end

	// Run needs about 17 us; a hang ends the same way
	initial begin
		#200000;
		failCount++;
		printVerdict();
	end
endmodule
